// ===== common/dnst_pkg.sv
// Purpose: Shared constants for the dual network switch timing block
// Assumes: 125 MHz sys_clk, millisecond settings
// Notes:   Mode and protocol codes are local encodings
package dnst_pkg;
    localparam int unsigned CLK_HZ          = 125000000;
    localparam int unsigned TICK_MS_CYCLES  = CLK_HZ / 1000;
    localparam int unsigned MS_W            = 16;
    localparam logic [15:0] CTS_WAIT_DEF    = 16'h0000;
    localparam logic [15:0] REVERT_IDLE_DEF = 16'h012c;
    localparam logic [15:0] RESP_DELAY_DEF  = 16'h03e8;
    localparam logic [15:0] DEKEY_DEF       = 16'h0000;
    localparam logic [15:0] PREV_INT_DEF    = 16'h0000;
    localparam logic [15:0] PREV_DUR_DEF    = 16'h0000;
    localparam logic [15:0] LEG_SW_DEF      = 16'h0000;
    localparam logic [15:0] LEG_SW_RECOMMEND = 16'h0096;
    localparam logic [7:0]  RADIUS_ONE_HOP  = 8'h01;
    localparam int unsigned FIFO_DEPTH      = 32;
    localparam int unsigned DATA_W          = 8;
    localparam logic        NET_LEGACY      = 1'b0;
    localparam logic        NET_NEW         = 1'b1;
    localparam logic [1:0]  MODE_OTHER      = 2'h0;
    localparam logic [1:0]  MODE_BASE_MIG   = 2'h1;
    localparam logic [1:0]  MODE_RPT_MIG    = 2'h2;
    localparam logic [2:0]  PROTO_MODBUS_RTU = 3'h0;
    localparam logic [2:0]  PROTO_MULTI_A   = 3'h6;
    localparam logic [2:0]  PROTO_MULTI_B   = 3'h7;
    typedef enum logic [2:0] {
        ST_IDLE, ST_CTS_WAIT, ST_SEND, ST_DEKEY, ST_RESP_WAIT, ST_RX, ST_REVERT_IDLE
    } dnst_state_t;
endpackage

// ===== rtl/dnst_fifo.sv
// Purpose: Poll byte buffer, defined beside the switch timing top
// Assumes: Nothing is declared here
// Notes:   Intentionally empty

// ===== rtl/dnst_top.sv
`timescale 1ns/10ps
// Purpose: Switch timing between legacy and new radio networks
// Assumes: Settings are static ports; serial pins asynchronous
// Notes:   One millisecond tick drives all timers
module dnst_top
    import dnst_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = TICK_MS_CYCLES
) (
    input  wire logic              sys_clk,       // System clock 125 MHz
    input  wire logic              nrst,          // Async reset, active low
    input  wire logic [1:0]        term_mode,     // Terminal operating mode
    input  wire logic              pref_net,      // Preferred network, 1 = new
    input  wire logic              lock_legacy,   // Switch locked to legacy
    input  wire logic [MS_W-1:0]   cts_wait_ms,   // Max CTS wait
    input  wire logic [MS_W-1:0]   revert_idle_ms,// Auto revert idle
    input  wire logic [MS_W-1:0]   resp_delay_ms, // Network response delay
    input  wire logic [MS_W-1:0]   dekey_ms,      // Soft carrier de-key delay
    input  wire logic [MS_W-1:0]   prev_int_ms,   // Periodic revert interval
    input  wire logic [MS_W-1:0]   prev_dur_ms,   // Periodic revert duration
    input  wire logic [MS_W-1:0]   leg_sw_ms,     // Legacy switch delay
    input  wire logic [7:0]        net_radius,    // Network radius in hops
    input  wire logic [2:0]        proto_sel,     // Protocol selection
    input  wire logic [2:0]        proto_detect,  // Protocol found in traffic
    input  wire logic [DATA_W-1:0] poll_data,     // Poll byte toward legacy
    input  wire logic              poll_valid,    // Poll byte valid
    input  wire logic              poll_last,     // Last byte of poll
    output logic                   poll_ready,    // FIFO accepts byte
    output logic [DATA_W-1:0]      ser_data,      // Serial byte out
    output logic                   ser_valid,     // Serial byte strobe
    input  wire logic              ser_ready,     // Serial transmitter ready
    input  wire logic              rts_pin,       // RTS from legacy radio
    input  wire logic              rx_byte_pin,   // Response byte seen, async
    input  wire logic              rx_end_pin,    // Response end, async
    output logic                   cts_q,         // CTS to legacy radio
    output logic                   net_sel_q,     // Switch position, 1 = new
    output logic                   timeout_q,     // Response timeout pulse
    output logic [2:0]             proto_q        // Active protocol
);
    // ------------------------------------------------------------
    // Synchronisers and tick
    // ------------------------------------------------------------
    logic [2:0] s1_q;
    logic [2:0] s2_q;
    logic [2:0] s3_q;
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= {rx_end_pin, rx_byte_pin, rts_pin};
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end
    wire rts_s   = s2_q[0];
    wire rx_byte = s2_q[1] && !s3_q[1];
    wire rx_end  = s2_q[2] && !s3_q[2];

    logic [$clog2(TICK_CYCLES)-1:0] tdiv_q;
    logic                           tick_q;
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            tdiv_q <= '0;
            tick_q <= 1'b0;
        end else if (tdiv_q == ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1)) begin
            tdiv_q <= '0;
            tick_q <= 1'b1;
        end else begin
            tdiv_q <= tdiv_q + 1'b1;
            tick_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------
    wire mig_on   = (term_mode == MODE_BASE_MIG) || (term_mode == MODE_RPT_MIG);
    wire base_on  = term_mode == MODE_BASE_MIG;
    wire rpt_on   = term_mode == MODE_RPT_MIG;
    wire prev_on  = base_on && (prev_int_ms != '0) && !lock_legacy;
    wire lsd_on   = rpt_on && (net_radius > RADIUS_ONE_HOP);

    // ------------------------------------------------------------
    // Data FIFO
    // ------------------------------------------------------------
    logic [DATA_W-1:0] f_data;
    logic              f_valid;
    logic              f_ready;
    logic              last_q;
    dnst_fifo #(.WIDTH(DATA_W + 1), .DEPTH(FIFO_DEPTH)) u_fifo (
        .sys_clk  (sys_clk),
        .nrst     (nrst),
        .in_data  ({poll_last, poll_data}),
        .in_valid (poll_valid),
        .in_ready (poll_ready),
        .out_data ({last_q, f_data}),
        .out_valid(f_valid),
        .out_ready(f_ready)
    );

    // ------------------------------------------------------------
    // Poll sequencer
    // ------------------------------------------------------------
    dnst_state_t     st_q;
    logic [MS_W-1:0] cnt_q;
    logic            forced_q;
    wire             cnt_done = cnt_q == '0;
    wire             poll_busy = (st_q != ST_IDLE) && (st_q != ST_REVERT_IDLE);
    wire             sending = st_q == ST_SEND;
    logic [MS_W-1:0] leg_ms_q;
    logic [MS_W-1:0] frc_ms_q;
    // A due revert holds off a new poll so the two never start together
    wire             force_due = prev_on && !forced_q && (net_sel_q == NET_LEGACY)
                                 && (leg_ms_q >= prev_int_ms) && !poll_busy;

    assign f_ready = sending && ser_ready && !ser_valid;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            st_q      <= ST_IDLE;
            cnt_q     <= '0;
            cts_q     <= 1'b0;
            timeout_q <= 1'b0;
        end else begin
            timeout_q <= 1'b0;
            if (tick_q && !cnt_done) cnt_q <= cnt_q - 1'b1;
            case (st_q)
                ST_IDLE, ST_REVERT_IDLE: begin
                    if (mig_on && f_valid && !forced_q && !force_due) begin
                        st_q  <= ST_CTS_WAIT;
                        cts_q <= 1'b1;
                        // Repeater forwarding delay folds into the wait
                        cnt_q <= lsd_on ? cts_wait_ms + leg_sw_ms : cts_wait_ms;
                    end else if (st_q == ST_REVERT_IDLE && cnt_done) begin
                        st_q <= ST_IDLE;
                    end
                end
                ST_CTS_WAIT: begin
                    if (cnt_done || (rts_s && !lsd_on)) st_q <= ST_SEND;
                end
                ST_SEND: begin
                    if (f_ready && f_valid && last_q) begin
                        st_q  <= ST_DEKEY;
                        cnt_q <= dekey_ms;
                    end
                end
                ST_DEKEY: begin
                    if (cnt_done) begin
                        st_q  <= ST_RESP_WAIT;
                        cts_q <= 1'b0;
                        cnt_q <= resp_delay_ms;
                    end
                end
                ST_RESP_WAIT: begin
                    if (rx_byte) begin
                        st_q <= ST_RX;
                    end else if (cnt_done) begin
                        timeout_q <= 1'b1;
                        st_q      <= ST_REVERT_IDLE;
                        cnt_q     <= revert_idle_ms;
                    end
                end
                ST_RX: begin
                    if (rx_end) begin
                        st_q  <= ST_REVERT_IDLE;
                        cnt_q <= revert_idle_ms;
                    end
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ser_valid <= 1'b0;
            ser_data  <= '0;
        end else begin
            ser_valid <= f_ready && f_valid;
            if (f_ready && f_valid) ser_data <= f_data;
        end
    end

    // ------------------------------------------------------------
    // Periodic revert
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            leg_ms_q <= '0;
            frc_ms_q <= '0;
            forced_q <= 1'b0;
        end else if (!prev_on) begin
            leg_ms_q <= '0;
            forced_q <= 1'b0;
        end else if (forced_q) begin
            if (tick_q) frc_ms_q <= frc_ms_q + 1'b1;
            if (frc_ms_q >= prev_dur_ms) begin
                forced_q <= 1'b0;
                leg_ms_q <= '0;
            end
        end else if (net_sel_q == NET_LEGACY) begin
            if (tick_q && leg_ms_q < prev_int_ms) leg_ms_q <= leg_ms_q + 1'b1;
            if (leg_ms_q >= prev_int_ms && !poll_busy) begin
                forced_q <= 1'b1;
                frc_ms_q <= '0;
            end
        end else begin
            leg_ms_q <= '0;
        end
    end

    // ------------------------------------------------------------
    // Switch position and protocol
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            net_sel_q <= NET_NEW;
        end else if (!mig_on) begin
            net_sel_q <= NET_NEW;
        end else if (forced_q) begin
            net_sel_q <= NET_NEW;
        end else if (lock_legacy || poll_busy) begin
            net_sel_q <= NET_LEGACY;
        end else if (st_q == ST_IDLE) begin
            net_sel_q <= pref_net;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            proto_q <= PROTO_MODBUS_RTU;
        end else if (proto_sel == PROTO_MULTI_A || proto_sel == PROTO_MULTI_B) begin
            proto_q <= proto_detect;
        end else begin
            proto_q <= proto_sel;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_resp_timeout;
        (st_q == ST_RESP_WAIT) && cnt_done && !rx_byte;
    endsequence
    a_cts_wait_bound: assert property (@(posedge sys_clk) disable iff (!nrst)
        (st_q == ST_CTS_WAIT) && cnt_done |=> st_q == ST_SEND)
        else $error("CTS wait overran");
    a_rts_starts: assert property (@(posedge sys_clk) disable iff (!nrst)
        (st_q == ST_CTS_WAIT) && rts_s && !lsd_on |=> st_q == ST_SEND)
        else $error("RTS did not start data");
    a_idle_pref: assert property (@(posedge sys_clk) disable iff (!nrst)
        (st_q == ST_IDLE) && mig_on && !forced_q && !lock_legacy |=> net_sel_q == $past(pref_net))
        else $error("Switch not at preferred network");
    a_revert_load: assert property (@(posedge sys_clk) disable iff (!nrst)
        (st_q == ST_RX) && rx_end |=> (st_q == ST_REVERT_IDLE) && cnt_q == $past(revert_idle_ms))
        else $error("Revert idle not started");
    a_resp_timeout: assert property (@(posedge sys_clk) disable iff (!nrst)
        s_resp_timeout |=> timeout_q && st_q == ST_REVERT_IDLE)
        else $error("Response timeout missed");
    a_dekey_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
        (st_q == ST_DEKEY) && !cnt_done |=> cts_q)
        else $error("CTS dropped during de-key");
    a_forced_new: assert property (@(posedge sys_clk) disable iff (!nrst)
        forced_q && mig_on |=> net_sel_q == NET_NEW)
        else $error("Forced revert not on new network");
    a_no_force_busy: assert property (@(posedge sys_clk) disable iff (!nrst)
        $rose(forced_q) |-> !$past(poll_busy) && !$past(lock_legacy))
        else $error("Forced revert during poll or lock");
    a_base_only: assert property (@(posedge sys_clk) disable iff (!nrst)
        !base_on |=> !forced_q)
        else $error("Periodic revert outside base mode");
    a_mig_gate: assert property (@(posedge sys_clk) disable iff (!nrst)
        !mig_on && (st_q == ST_IDLE) |=> st_q == ST_IDLE)
        else $error("Poll started outside migration mode");
    sequence s_poll_start;
        (st_q == ST_IDLE || st_q == ST_REVERT_IDLE) && mig_on && f_valid && !forced_q && !force_due;
    endsequence
    a_master_no_lsd: assert property (@(posedge sys_clk) disable iff (!nrst)
        s_poll_start ##0 !rpt_on |=> cnt_q == $past(cts_wait_ms))
        else $error("Switch delay applied outside repeater mode");
    a_force_no_poll: assert property (@(posedge sys_clk) disable iff (!nrst)
        forced_q |-> !poll_busy)
        else $error("Forced revert overlaps a poll");
    a_lock_holds: assert property (@(posedge sys_clk) disable iff (!nrst)
        mig_on && lock_legacy && !forced_q |=> net_sel_q == NET_LEGACY)
        else $error("Lock did not hold legacy network");
endmodule

// ------------------------------------------------------------
// Poll byte buffer
// ------------------------------------------------------------
// Ready is registered from the next pointers so it leaves a flop
module dnst_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 32
) (
    input  wire logic             sys_clk,  // System clock
    input  wire logic             nrst,     // Async reset, active low
    input  wire logic [WIDTH-1:0] in_data,  // Write data
    input  wire logic             in_valid, // Write valid
    output logic                  in_ready, // Not full, registered
    output logic      [WIDTH-1:0] out_data, // Read data
    output logic                  out_valid,// Not empty
    input  wire logic             out_ready // Read accept
);
    localparam int unsigned AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_q;
    logic [AW:0]      wr_d;
    logic [AW:0]      rd_q;
    logic [AW:0]      rd_d;
    wire              push = in_valid && in_ready;
    wire              pop  = out_valid && out_ready;

    assign wr_d      = push ? wr_q + 1'b1 : wr_q;
    assign rd_d      = pop ? rd_q + 1'b1 : rd_q;
    assign out_valid = wr_q != rd_q;
    assign out_data  = mem[rd_q[AW-1:0]];

    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wr_q[AW-1:0]] <= in_data;
        end
    end
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            wr_q     <= '0;
            rd_q     <= '0;
            in_ready <= 1'b1;
        end else begin
            wr_q     <= wr_d;
            rd_q     <= rd_d;
            in_ready <= (wr_d - rd_d) != (AW+1)'(DEPTH);
        end
    end
endmodule

// ===== sim/dnst_legacy_radio.sv
`timescale 1ns/10ps
// Purpose: Behavioural legacy radio on the serial handshake side
// Assumes: Driven from sys_clk, responses shortly after CTS drops
// Notes:   rts_dly of zero keeps the RTS pin low
module dnst_legacy_radio (
    input  wire logic       sys_clk,     // System clock
    input  wire logic       nrst,        // Async reset, active low
    input  wire logic       cts_q,       // CTS from the station
    input  wire logic [7:0] rts_dly,     // Cycles until RTS, 0 = never
    input  wire logic       respond,     // Answer polls
    output logic            rts_pin,     // RTS toward the station
    output logic            ser_ready,   // Transmitter ready
    output logic            rx_byte_pin, // Response byte seen
    output logic            rx_end_pin   // Response end
);
    logic [7:0] cnt_q;
    logic [2:0] stall_q;
    // ----------------------------------------
    // Key-up handshake
    // ----------------------------------------
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_q   <= 8'h00;
            rts_pin <= 1'b0;
        end else if (!cts_q) begin
            cnt_q   <= 8'h00;
            rts_pin <= 1'b0;
        end else begin
            cnt_q   <= (cnt_q == 8'hff) ? cnt_q : cnt_q + 8'h01;
            rts_pin <= (rts_dly != 8'h00) && (cnt_q >= rts_dly);
        end
    end
    // Stalls one cycle in eight so the pop path sees back pressure
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) stall_q <= 3'h0;
        else stall_q <= stall_q + 3'h1;
    end
    assign ser_ready = (stall_q != 3'h7);
    initial begin
        rx_byte_pin = 1'b0;
        rx_end_pin  = 1'b0;
    end
    always @(negedge cts_q) begin
        if (respond && nrst) begin
            repeat (12) @(posedge sys_clk);
            #1 rx_byte_pin = 1'b1;
            repeat (3) @(posedge sys_clk);
            #1 rx_byte_pin = 1'b0;
            repeat (6) @(posedge sys_clk);
            #1 rx_end_pin = 1'b1;
            repeat (3) @(posedge sys_clk);
            #1 rx_end_pin = 1'b0;
        end
    end
endmodule

// ===== sim/dnst_top_tb_top.sv
`timescale 1ns/10ps
// Purpose: Self-checking bench for the switch timing block
// Assumes: One ms is T cycles of an 8 ns clock
// Notes:   Bounds allow one tick of timer granularity plus sync delay
module dnst_top_tb_top;
    import dnst_pkg::*;
    localparam int T = 4;
    logic sys_clk = 1'b0, nrst = 1'b0, pref_net = NET_NEW, lock_legacy = 1'b0;
    logic [1:0] term_mode = MODE_OTHER;
    logic [MS_W-1:0] cts_w = 16'h0000, idle_w = 16'h0005, resp_w = 16'h0014, dekey_w = 16'h0002;
    logic [MS_W-1:0] pint_w = 16'h0000, pdur_w = 16'h0000, lsw_w = 16'h0000;
    logic [7:0] radius = 8'h01, rts_dly = 8'h00;
    logic [2:0] psel = PROTO_MODBUS_RTU, pdet = 3'h0, proto_q;
    logic [DATA_W-1:0] poll_data = 8'h00, ser_data;
    logic poll_valid = 1'b0, poll_last = 1'b0, poll_ready, ser_valid, ser_ready, respond = 1'b1;
    logic rts_pin, rx_byte_pin, rx_end_pin, cts_q, net_sel_q, timeout_q;
    int failures = 0, checked = 0, c, n;
    logic [DATA_W-1:0] rxq[$];
    always #4 sys_clk = ~sys_clk;
    dnst_top #(.TICK_CYCLES(T)) uut (.sys_clk(sys_clk), .nrst(nrst), .term_mode(term_mode),
        .pref_net(pref_net), .lock_legacy(lock_legacy), .cts_wait_ms(cts_w), .revert_idle_ms(idle_w),
        .resp_delay_ms(resp_w), .dekey_ms(dekey_w), .prev_int_ms(pint_w), .prev_dur_ms(pdur_w),
        .leg_sw_ms(lsw_w), .net_radius(radius), .proto_sel(psel), .proto_detect(pdet),
        .poll_data(poll_data), .poll_valid(poll_valid), .poll_last(poll_last), .poll_ready(poll_ready),
        .ser_data(ser_data), .ser_valid(ser_valid), .ser_ready(ser_ready), .rts_pin(rts_pin),
        .rx_byte_pin(rx_byte_pin), .rx_end_pin(rx_end_pin), .cts_q(cts_q), .net_sel_q(net_sel_q),
        .timeout_q(timeout_q), .proto_q(proto_q));
    dnst_legacy_radio radio (.sys_clk(sys_clk), .nrst(nrst), .cts_q(cts_q), .rts_dly(rts_dly),
        .respond(respond), .rts_pin(rts_pin), .ser_ready(ser_ready), .rx_byte_pin(rx_byte_pin),
        .rx_end_pin(rx_end_pin));
    always @(negedge sys_clk) if (ser_valid === 1'b1) rxq.push_back(ser_data);
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input logic [15:0] e, input logic [15:0] a);
        checked++;
        if (a !== e) begin
            failures++;
            $display("BAD t=%0t exp=%h got=%h", $time, e, a);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask
    // Waits for an event; c is -1 when it never came
    task automatic wait_ev(input int which, input int lim, output int cnt);
        logic hit;
        cnt = 0;
        hit = 1'b0;
        while (!hit && cnt < lim) begin
            cyc(1);
            cnt++;
            case (which)
                0: hit = (ser_valid === 1'b1);
                1: hit = (cts_q === 1'b0);
                2: hit = (timeout_q === 1'b1);
                3: hit = (net_sel_q === NET_NEW);
                default: hit = (net_sel_q === NET_LEGACY);
            endcase
        end
        if (!hit) cnt = -1;
    endtask
    // Offers k bytes, returns how many were taken before a refusal
    task automatic push(input int k, output int got);
        logic ok;
        got = 0;
        for (int i = 0; i < k; i++) begin
            poll_data  = 8'h10 + 8'(i);
            poll_last  = (i == k - 1);
            poll_valid = 1'b1;
            ok = (poll_ready === 1'b1);
            cyc(1);
            if (ok) got++;
            else i = k;
        end
        poll_valid = 1'b0;
        poll_last  = 1'b0;
        cyc(1);
    endtask
    task automatic first_byte(input int k, output int cnt);
        push(k, n);
        wait_ev(0, 2000, cnt);
    endtask
    task automatic finish_test;
        $display("checked=%0d failures=%0d", checked, failures);
        if (failures == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        #480000;
        failures++;
        finish_test();
    end
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        cyc(3);
        nrst = 1'b1;
        cyc(1);
        chk(16'h0001, {15'h0, net_sel_q});
        chk(16'h0000, {cts_q, timeout_q, ser_valid, proto_q});
        push(32, n);
        chk(16'h0020, 16'(n));
        push(8, n);
        chk(16'h0000, 16'(n));
        cyc(40);
        chk(16'h0000, {15'h0, cts_q});
        rxq.delete();
        term_mode = MODE_BASE_MIG;
        wait_ev(0, 100, c);
        chk(16'h0001, 16'(c > 0 && c <= 4));
        for (int i = 0; i < 31; i++) wait_ev(0, 100, c);
        wait_ev(1, 400, c);
        chk(16'h0001, 16'(c >= (dekey_w - 1) * T));
        chk(16'h0020, 16'(rxq.size()));
        for (int i = 0; i < 32; i++) chk(16'h0010 + 16'(i), 16'(rxq[i]));
        wait_ev(2, 30 * T, c);
        chk(16'hffff, 16'(c));
        wait_ev(3, 40 * T, c);
        chk(16'h0001, 16'(c >= 0));
        cts_w   = 16'h000a;
        rts_dly = 8'h06;
        first_byte(2, c);
        chk(16'h0001, 16'(c > 0 && c <= 15));
        cyc(120 * T);
        rts_dly = 8'h00;
        first_byte(2, c);
        chk(16'h0001, 16'(c >= 9 * T && c <= 11 * T + 6));
        cyc(120 * T);
        respond  = 1'b0;
        pref_net = NET_LEGACY;
        cts_w    = 16'h0000;
        push(1, n);
        wait_ev(1, 400, c);
        wait_ev(2, 40 * T, c);
        chk(16'h0001, 16'(c >= 19 * T && c <= 21 * T + 6));
        wait_ev(3, 10 * T, c);
        chk(16'hffff, 16'(c));
        pint_w = 16'h000a;
        pdur_w = 16'h0008;
        wait_ev(3, 14 * T, c);
        chk(16'h0001, 16'(c >= 9 * T && c <= 11 * T + 4));
        wait_ev(4, 20 * T, c);
        chk(16'h0001, 16'(c >= 7 * T && c <= 9 * T + 4));
        lock_legacy = 1'b1;
        wait_ev(3, 40 * T, c);
        chk(16'hffff, 16'(c));
        lock_legacy = 1'b0;
        pint_w   = 16'h0000;
        pdur_w   = 16'h0000;
        pref_net = NET_NEW;
        respond  = 1'b1;
        wait_ev(3, 40 * T, c);
        cyc(10 * T);
        term_mode = MODE_RPT_MIG;
        lsw_w     = LEG_SW_RECOMMEND;
        radius    = 8'h02;
        first_byte(1, c);
        chk(16'h0001, 16'(c >= (int'(lsw_w) - 1) * T && c <= (int'(lsw_w) + 1) * T + 4));
        cyc(80 * T);
        radius = RADIUS_ONE_HOP;
        first_byte(1, c);
        chk(16'h0001, 16'(c > 0 && c <= 4));
        pdet = 3'h3;
        for (int p = 0; p < 8; p++) begin
            psel = 3'(p);
            cyc(4);
            chk((p >= 6) ? 16'h0003 : 16'(p), 16'(proto_q));
        end
        finish_test();
    end
endmodule
